// [pnpp_port.sv]
// parallel programming port: loads, program/erase sequencing, read-back
// assumes pins arrive asynchronously; strobe clock comes from the programmer
//
// Summary of operation
// - each strobe pulse loads address, data or command by action bits; 11 idles
// - command byte selects erase, fuse, lock, flash or eeprom write action
// - command bytes select signature, fuse/lock, flash or eeprom reads
// - ready_busy_n is low while a programming operation runs, high when ready
// - byte_select_lo picks low/high byte; byte_select_hi2 picks second high byte
// - data bus is driven only while output_enable_n is low
// - entry refused if byte_select_lo moves within 100 ns of high voltage
// - chip erase clears flash, eeprom, then lock bits; fuses untouched
// - erase command with write strobe low pulse starts erase, busy goes low
// - flash is 256 pages of 128 bytes, written through a page buffer
// - page latch pulse with byte_select_lo high stores one word in buffer
// - page number is address high six bits plus address low bits 7 and 6
// - write strobe after address high starts whole-page programming, busy low
// - no-operation command ends page programming and clears write state
// - eeprom write strobe with byte_select_lo low writes byte, busy until done
// - command and address stay loaded across operations
// - flash read drives low byte, then high byte with byte_select_lo high
// - eeprom read drives addressed byte with enable and select low
// - three identification bytes sit at locations 0 to 2 of own space
// - calibration byte sits in high byte of identification location 0
// - identification read drives selected byte with enable and select low
// - calibration read drives trim byte with enable low and select high
module pnpp_port #(
   parameter int ERASE_CYC = pnpp_pkg::T_ERASE_CYC,
   parameter int FLASH_CYC = pnpp_pkg::T_FLASH_CYC,
   parameter int WRITE_CYC = pnpp_pkg::T_WRITE_CYC,
   // identification and trim values below are arbitrary
   parameter logic [7:0] ID_BYTE0 = 8'h5a,
   parameter logic [7:0] ID_BYTE1 = 8'ha3,
   parameter logic [7:0] ID_BYTE2 = 8'h3c,
   parameter logic [7:0] OSC_TRIM = 8'h80
) (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic strobe_clock_in,
   input wire logic hv_reset_in,
   input wire logic strobe_action_0,
   input wire logic strobe_action_1,
   input wire logic byte_select_lo,
   input wire logic byte_select_hi2,
   input wire logic page_latch_pulse,
   input wire logic write_strobe_n,
   input wire logic output_enable_n,
   input wire logic [7:0] data_in,
   output logic [7:0] data_out,
   output logic data_oe,
   output logic ready_busy_n,
   output logic prog_mode
);
   import pnpp_pkg::*;

   // ==========================================================
   // helpers
   function automatic logic [13:0] word_addr(input logic [7:0] hi, input logic [7:0] lo);
      return {hi[5:0], lo};
   endfunction

   // ==========================================================
   // crossings
   pnpp_load_t load;
   logic load_toggle;
   logic [6:0] pins_s;
   logic hv_s, bs_lo_s, bs_hi2_s, page_latch_pulse_s, wr_n_s, oe_n_s, tog_s;
   logic hv_d, page_latch_pulse_d, wr_n_d, tog_d;

   pnpp_link u_link (
      .strobe_clock_in(strobe_clock_in),
      .rstn(rstn),
      .strobe_action({strobe_action_1, strobe_action_0}),
      .byte_select_lo(byte_select_lo),
      .data_in(data_in),
      .load(load),
      .load_toggle(load_toggle)
   );

   pnpp_sync #(.W(7)) u_pin_sync (
      .clk(clk_sys),
      .d({hv_reset_in, byte_select_lo, byte_select_hi2, page_latch_pulse,
          write_strobe_n, output_enable_n, load_toggle}),
      .q(pins_s)
   );

   assign {hv_s, bs_lo_s, bs_hi2_s, page_latch_pulse_s, wr_n_s, oe_n_s, tog_s} = pins_s;

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         hv_d <= 1'b0;
         page_latch_pulse_d <= 1'b0;
         wr_n_d <= 1'b1;
         tog_d <= 1'b0;
      end else begin
         hv_d <= hv_s;
         page_latch_pulse_d <= page_latch_pulse_s;
         wr_n_d <= wr_n_s;
         tog_d <= tog_s;
      end
   end

   wire ld_evt = (tog_s ^ tog_d) & prog_mode;
   wire wr_fall = wr_n_d & ~wr_n_s & prog_mode;
   wire page_latch_pulse_rise = page_latch_pulse_s & ~page_latch_pulse_d & prog_mode;

   // ==========================================================
   // programming mode entry
   logic [ENTRY_W-1:0] entry_cnt;
   logic entry_bs, entry_fail;

   always_ff @(posedge clk_sys) begin
      if (!rstn || !hv_s) begin
         prog_mode <= 1'b0;
         entry_cnt <= '0;
         entry_bs <= 1'b0;
         entry_fail <= 1'b0;
      end else if (!hv_d) begin
         entry_cnt <= ENTRY_W'(ENTRY_WIN_CYC);
         entry_bs <= bs_lo_s;
         entry_fail <= bs_lo_s;
      end else if (entry_cnt != '0) begin
         entry_cnt <= entry_cnt - 1'b1;
         // select must stay quiet through the window
         if (bs_lo_s != entry_bs) begin
            entry_fail <= 1'b1;
         end
      end else if (!entry_fail) begin
         prog_mode <= 1'b1;
      end
   end

   // ==========================================================
   // command, address and data loads
   logic [7:0] cmd, addr_lo, addr_hi, data_lo, data_hi;

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         cmd <= CMD_NOP;
         addr_lo <= '0;
         addr_hi <= '0;
         data_lo <= '0;
         data_hi <= '0;
      end else if (ld_evt) begin
         unique case (load.action)
            ACT_ADDR: if (load.bs_lo) addr_hi <= load.data; else addr_lo <= load.data;
            ACT_DATA: if (load.bs_lo) data_hi <= load.data; else data_lo <= load.data;
            ACT_CMD: cmd <= load.data;
            ACT_IDLE: ;
         endcase
      end
   end

   wire nop_load = ld_evt && load.action == ACT_CMD && load.data == CMD_NOP;
   wire [13:0] rd_word = word_addr(addr_hi, addr_lo);
   wire [7:0] page_num = {addr_hi[5:0], addr_lo[7:6]};
   wire [9:0] ee_addr = {addr_hi[1:0], addr_lo};

   // ==========================================================
   // operation sequencing
   pnpp_op_t op;
   logic [BUSY_W-1:0] busy_cnt;
   logic [13:0] walk;
   logic walk_done;
   logic [7:0] fuse_lo, fuse_hi, lock_bits;

   wire start_ok = wr_fall && op == OP_IDLE;
   wire start_erase = start_ok && cmd == CMD_ERASE && !bs_lo_s;
   wire start_flash = start_ok && cmd == CMD_WR_FLASH;
   wire start_ee = start_ok && cmd == CMD_WR_EE && !bs_lo_s;
   wire start_fuse = start_ok && cmd == CMD_WR_FUSE;
   wire start_lock = start_ok && cmd == CMD_WR_LOCK;
   wire start_any = start_erase | start_flash | start_ee | start_fuse | start_lock;
   wire [13:0] walk_last = (op == OP_ERASE) ? ERASE_LAST : PAGE_LAST;
   wire op_end = op != OP_IDLE && busy_cnt == '0 && walk_done;

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         op <= OP_IDLE;
         busy_cnt <= '0;
         walk <= '0;
         walk_done <= 1'b1;
      end else if (op == OP_IDLE) begin
         walk <= '0;
         walk_done <= ~(start_erase | start_flash);
         if (start_erase) begin
            op <= OP_ERASE;
            busy_cnt <= BUSY_W'(ERASE_CYC - 1);
         end else if (start_flash) begin
            op <= OP_FLASH;
            busy_cnt <= BUSY_W'(FLASH_CYC - 1);
         end else if (start_ee | start_fuse | start_lock) begin
            op <= start_ee ? OP_EEPROM : (start_fuse ? OP_FUSE : OP_LOCK);
            busy_cnt <= BUSY_W'(WRITE_CYC - 1);
         end
      end else begin
         if (busy_cnt != '0) begin
            busy_cnt <= busy_cnt - 1'b1;
         end
         if (!walk_done) begin
            walk <= walk + 1'b1;
            walk_done <= walk == walk_last;
         end
         if (op_end) begin
            op <= OP_IDLE;
         end
      end
   end

   // busy from the strobe that starts an op until it ends
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         ready_busy_n <= 1'b1;
      end else begin
         ready_busy_n <= !(start_any || (op != OP_IDLE && !op_end));
      end
   end

   // fuses survive erase; lock bits go back only once the walk is over
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         fuse_lo <= FUSE_LO_RST;
         fuse_hi <= FUSE_HI_RST;
         lock_bits <= LOCK_RST;
      end else if (op == OP_ERASE && op_end) begin
         lock_bits <= LOCK_RST;
      end else if (start_fuse) begin
         if (bs_lo_s) fuse_hi <= data_lo; else fuse_lo <= data_lo;
      end else if (start_lock) begin
         lock_bits <= lock_bits & data_lo;
      end
   end

   // ==========================================================
   // storage
   logic [15:0] flash_mem [FLASH_WORDS];
   logic [7:0] ee_mem [EE_BYTES];
   logic [15:0] page_buf [PAGE_WORDS];
   logic page_dirty;

   wire [13:0] prog_word = {page_num, walk[5:0]};

   // cells only clear on erase and only lose ones on write, so an
   // unerased page cannot be turned back to ones by programming
   always_ff @(posedge clk_sys) begin
      if (op == OP_ERASE && !walk_done) begin
         flash_mem[walk] <= WORD_ERASED;
         if (walk < 14'(EE_BYTES)) begin
            ee_mem[walk[9:0]] <= BYTE_ERASED;
         end
      end
      if (op == OP_FLASH && !walk_done) begin
         flash_mem[prog_word] <= flash_mem[prog_word] & page_buf[walk[5:0]];
      end
      if (start_ee) begin
         ee_mem[ee_addr] <= ee_mem[ee_addr] & data_lo;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn || nop_load || (op == OP_FLASH && op_end)) begin
         for (int i = 0; i < PAGE_WORDS; i++) begin
            page_buf[i] <= WORD_ERASED;
         end
         page_dirty <= 1'b0;
      end else if (page_latch_pulse_rise && bs_lo_s) begin
         page_buf[addr_lo[5:0]] <= {data_hi, data_lo};
         page_dirty <= 1'b1;
      end
   end

   // ==========================================================
   // read-back
   wire [15:0] flash_word = flash_mem[rd_word];
   wire [7:0] ee_byte = ee_mem[ee_addr];
   wire [7:0] id_byte = (addr_lo == 8'h00) ? ID_BYTE0 :
                        (addr_lo == 8'h01) ? ID_BYTE1 :
                        (addr_lo == 8'h02) ? ID_BYTE2 : BYTE_ERASED;
   wire [7:0] sig_byte = bs_lo_s ? ((addr_lo == 8'h00) ? OSC_TRIM : BYTE_ERASED)
                                 : id_byte;
   wire [7:0] fuse_byte = ({bs_hi2_s, bs_lo_s} == 2'h0) ? fuse_lo :
                          ({bs_hi2_s, bs_lo_s} == 2'h3) ? fuse_hi :
                          ({bs_hi2_s, bs_lo_s} == 2'h1) ? lock_bits : BYTE_ERASED;
   wire [7:0] rd_byte = (cmd == CMD_RD_FLASH) ? (bs_lo_s ? flash_word[15:8]
                                                         : flash_word[7:0]) :
                        (cmd == CMD_RD_EE) ? ee_byte :
                        (cmd == CMD_RD_SIG) ? sig_byte :
                        (cmd == CMD_RD_FUSE) ? fuse_byte : BYTE_ERASED;
   wire drive = prog_mode && !oe_n_s;

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         data_oe <= 1'b0;
         data_out <= '0;
      end else begin
         data_oe <= drive;
         data_out <= drive ? rd_byte : 8'h00;
      end
   end

   // ==========================================================
   // checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);

   erase_busy_a: assert property (start_erase |=> !ready_busy_n && op == OP_ERASE)
      else $error("erase start did not raise busy");
   cmd_load_a: assert property (ld_evt && load.action == ACT_CMD |=> cmd == $past(load.data))
      else $error("command byte not loaded");
   addr_hi_a: assert property (ld_evt && load.action == ACT_ADDR && load.bs_lo
                               |=> addr_hi == $past(load.data) && $stable(addr_lo))
      else $error("high address byte load wrong");
   bus_drive_a: assert property (data_oe |-> $past(!oe_n_s) && prog_mode)
      else $error("bus driven without output enable");
   page_latch_a: assert property (page_latch_pulse_rise && bs_lo_s && !nop_load && !op_end
                                  |=> page_dirty)
      else $error("page latch lost");
   nop_clear_a: assert property (nop_load |=> !page_dirty && page_buf[0] == WORD_ERASED)
      else $error("no-op left page write state");
   erase_lock_a: assert property (op == OP_ERASE && op_end
                                  |=> lock_bits == LOCK_RST && op == OP_IDLE ##1 ready_busy_n)
      else $error("erase end did not clear lock bits");
   entry_refuse_a: assert property (entry_fail |-> !prog_mode)
      else $error("entered mode after select moved");
   ready_idle_a: assert property (op == OP_IDLE && !start_any [*2] |-> ready_busy_n)
      else $error("busy while nothing runs");
   busy_hold_a: assert property (op == OP_FLASH && !op_end |=> !ready_busy_n)
      else $error("ready while page programming runs");
   // writes that the programmer starts with a write strobe, and the read-back drive
   fuse_write_a: assert property (start_fuse && !bs_lo_s |=> fuse_lo == $past(data_lo))
      else $error("fuse low byte not written");
   lock_write_a: assert property (start_lock
                                  |=> lock_bits == ($past(lock_bits) & $past(data_lo)))
      else $error("lock bits not written");
   ee_start_a: assert property (start_ee |=> !ready_busy_n && op == OP_EEPROM)
      else $error("eeprom write did not raise busy");
   flash_start_a: assert property (start_flash |=> !ready_busy_n && !walk_done)
      else $error("page write did not start");
   read_data_a: assert property (data_oe |-> data_out == $past(rd_byte))
      else $error("read byte not driven");
endmodule

// [pnpp_pkg.sv]
// constants, codes and carrier types of the parallel programming port
// assumes a 40 MHz system clock and a programmer-driven strobe clock
package pnpp_pkg;

   // ==========================================================
   // timing
   localparam int CLK_SYS_MHZ = 40;
   localparam int ENTRY_WIN_NS = 100;
   // least time: rounded up to whole cycles
   localparam int ENTRY_WIN_CYC = (ENTRY_WIN_NS * CLK_SYS_MHZ + 999) / 1000;
   localparam int T_WRITE_US = 1500;
   localparam int T_ERASE_US = 23000;
   localparam int T_FLASH_US = 12000;
   localparam int T_WRITE_CYC = T_WRITE_US * CLK_SYS_MHZ;
   localparam int T_ERASE_CYC = T_ERASE_US * CLK_SYS_MHZ;
   localparam int T_FLASH_CYC = T_FLASH_US * CLK_SYS_MHZ;
   localparam int BUSY_W = 20;
   localparam int ENTRY_W = 4;

   // ==========================================================
   // strobe actions and command bytes
   localparam logic [1:0] ACT_ADDR = 2'h0;
   localparam logic [1:0] ACT_DATA = 2'h1;
   localparam logic [1:0] ACT_CMD = 2'h2;
   localparam logic [1:0] ACT_IDLE = 2'h3;
   localparam logic [7:0] CMD_NOP = 8'h00;
   localparam logic [7:0] CMD_ERASE = 8'h80;
   localparam logic [7:0] CMD_WR_FUSE = 8'h40;
   localparam logic [7:0] CMD_WR_LOCK = 8'h20;
   localparam logic [7:0] CMD_WR_FLASH = 8'h10;
   localparam logic [7:0] CMD_WR_EE = 8'h11;
   localparam logic [7:0] CMD_RD_SIG = 8'h08;
   localparam logic [7:0] CMD_RD_FUSE = 8'h04;
   localparam logic [7:0] CMD_RD_FLASH = 8'h02;
   localparam logic [7:0] CMD_RD_EE = 8'h03;

   // ==========================================================
   // memory shape
   localparam int FLASH_WORDS = 16384;
   localparam int PAGE_WORDS = 64;
   localparam int EE_BYTES = 1024;
   localparam logic [13:0] ERASE_LAST = 14'h3fff;
   localparam logic [13:0] PAGE_LAST = 14'h003f;
   localparam logic [15:0] WORD_ERASED = 16'hffff;
   localparam logic [7:0] BYTE_ERASED = 8'hff;
   localparam logic [7:0] FUSE_LO_RST = 8'hff;
   localparam logic [7:0] FUSE_HI_RST = 8'hff;
   localparam logic [7:0] LOCK_RST = 8'hff;

   typedef struct packed {
      logic [1:0] action;
      logic bs_lo;
      logic [7:0] data;
   } pnpp_load_t;

   typedef enum logic [2:0] {OP_IDLE, OP_ERASE, OP_FLASH, OP_EEPROM, OP_FUSE, OP_LOCK} pnpp_op_t;

endpackage

// [pnpp_sync.sv]
// two-flop synchroniser for a bundle of independent levels
// assumes each bit is a slow level; no bus coherence is implied
module pnpp_sync #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta;

   always_ff @(posedge clk) begin
      meta <= d;
      q <= meta;
   end
endmodule

// [pnpp_link.sv]
// strobe-clock side: captures action, byte select and data on each non-idle strobe
// assumes pins are set up around the strobe edge by the programmer
module pnpp_link
   import pnpp_pkg::*;
(
   input wire logic strobe_clock_in,
   input wire logic rstn,
   input wire logic [1:0] strobe_action,
   input wire logic byte_select_lo,
   input wire logic [7:0] data_in,
   output pnpp_load_t load,
   output logic load_toggle
);
   logic link_rstn;

   pnpp_sync #(.W(1)) u_rst_sync (
      .clk(strobe_clock_in),
      .d(rstn),
      .q(link_rstn)
   );

   // the hold register stays put until the next strobe, which is what lets
   // the system side read it after the toggle crossing
   always_ff @(posedge strobe_clock_in) begin
      if (!link_rstn) begin
         load <= '0;
         load_toggle <= 1'b0;
      end else if (strobe_action != ACT_IDLE) begin
         load <= '{action: strobe_action, bs_lo: byte_select_lo, data: data_in};
         load_toggle <= ~load_toggle;
      end
   end
endmodule

// [pnpp_prog.sv]
// programmer model: moves the port pins as a parallel programmer would
// assumes the bench calls one task at a time; pins move just after clk_sys rises
module pnpp_prog (
   input wire logic clk_sys,
   input wire logic [7:0] bus,
   output logic strobe_clock_in,
   output logic hv,
   output logic [1:0] act,
   output logic bs_lo,
   output logic bs_hi2,
   output logic page_latch,
   output logic wr_n,
   output logic oe_n,
   output logic drive,
   output logic [7:0] wdata
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      strobe_clock_in = 1'b0;
      hv = 1'b0;
      act = 2'h3;
      bs_lo = 1'b0;
      bs_hi2 = 1'b0;
      page_latch = 1'b0;
      wr_n = 1'b1;
      oe_n = 1'b1;
      drive = 1'b1;
      wdata = 8'h00;
   end
   task automatic hold(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   // ==========================================================
   // link clock: runs only inside a frame, offset from clk_sys
   task automatic pulses(input int n);
      repeat (n) begin
         #9;
         strobe_clock_in = 1'b1;
         #32;
         strobe_clock_in = 1'b0;
         #23;
      end
   endtask
   // 22-cycle spacing keeps every pulse gap above 500 ns
   task automatic load(input logic [1:0] a, input logic b, input logic [7:0] d);
      @(posedge clk_sys);
      act <= a;
      bs_lo <= b;
      wdata <= d;
      hold(3);
      pulses(1);
      hold(16);
      act <= 2'h3;
   endtask
   // glitch moves byte select inside the entry window
   task automatic enter(input logic glitch);
      @(posedge clk_sys);
      bs_lo <= 1'b0;
      hold(5);
      hv <= 1'b1;
      if (glitch) begin
         hold(1);
         bs_lo <= 1'b1;
         hold(1);
         bs_lo <= 1'b0;
      end
      hold(30);
   endtask
   task automatic leave();
      hv <= 1'b0;
      hold(10);
   endtask
   task automatic latch();
      bs_lo <= 1'b1;
      hold(3);
      page_latch <= 1'b1;
      hold(20);
      page_latch <= 1'b0;
      hold(20);
   endtask
   task automatic write_pulse(input logic b);
      bs_lo <= b;
      hold(3);
      wr_n <= 1'b0;
      hold(20);
      wr_n <= 1'b1;
   endtask
   // bus released for the read; device must drive it
   task automatic read(input logic b2, input logic b, output logic [7:0] q);
      bs_lo <= b;
      bs_hi2 <= b2;
      drive <= 1'b0;
      hold(3);
      oe_n <= 1'b0;
      hold(20);
      q = bus;
      oe_n <= 1'b1;
      hold(10);
      drive <= 1'b1;
      hold(3);
   endtask
endmodule

// [pnpp_tb.sv]
// self-checking bench for the parallel programming port
// assumes short busy counts; the programmer model drives every pin but clk_sys and rstn
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import pnpp_pkg::*;
   localparam int ER_CYC = 20000;
   localparam int FL_CYC = 200;
   localparam int WR_CYC = 50;
   // identification values are arbitrary
   localparam logic [7:0] ID0 = 8'h11;
   // bytes 1 and 2 are left at the port's own arbitrary values
   localparam logic [7:0] ID1 = 8'ha3;
   localparam logic [7:0] ID2 = 8'h3c;
   localparam logic [7:0] TRIM = 8'h44;
   logic clk_sys, rstn, strobe_clock_in, hv, bs_lo, bs_hi2, page_latch, wr_n, oe_n, drive;
   logic [1:0] act;
   logic [7:0] wdata, data_out, q, qh, pg, fv, lv;
   logic data_oe, ready_busy_n, prog_mode;
   logic [15:0] img[64];
   logic [9:0] ea;
   logic [7:0] ed[2];
   wire logic [7:0] bus;
   int seed, error_cnt, check_count;
   // released bus shows the inverse of wdata, never the last driven value
   assign bus = data_oe ? data_out : (drive ? wdata : ~wdata);
   pnpp_port #(.ERASE_CYC(ER_CYC), .FLASH_CYC(FL_CYC), .WRITE_CYC(WR_CYC), .ID_BYTE0(ID0),
      .OSC_TRIM(TRIM)) u_pnpp_port (.clk_sys(clk_sys),
      .rstn(rstn), .strobe_clock_in(strobe_clock_in), .hv_reset_in(hv),
      .strobe_action_0(act[0]), .strobe_action_1(act[1]), .byte_select_lo(bs_lo),
      .byte_select_hi2(bs_hi2), .page_latch_pulse(page_latch), .write_strobe_n(wr_n),
      .output_enable_n(oe_n), .data_in(bus), .data_out(data_out), .data_oe(data_oe),
      .ready_busy_n(ready_busy_n), .prog_mode(prog_mode));
   pnpp_prog u_pnpp_prog (.clk_sys(clk_sys), .bus(bus), .strobe_clock_in(strobe_clock_in),
      .hv(hv), .act(act), .bs_lo(bs_lo), .bs_hi2(bs_hi2), .page_latch(page_latch),
      .wr_n(wr_n), .oe_n(oe_n), .drive(drive), .wdata(wdata));
   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end
   // ==========================================================
   // checking and closing
   function automatic logic [7:0] sig_exp(input logic [7:0] a, input logic b);
      if (b) return (a == 8'h00) ? TRIM : BYTE_ERASED;
      return (a == 8'h00) ? ID0 : (a == 8'h01) ? ID1 : (a == 8'h02) ? ID2 : BYTE_ERASED;
   endfunction
   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic stop_test();
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // busy must last about the whole count, never forever
   task automatic wait_ready(input int cyc);
      int n;
      n = 0;
      while (ready_busy_n !== 1'b1 && n < cyc + 100) begin
         @(posedge clk_sys);
         n++;
      end
      if (ready_busy_n !== 1'b1) begin
         check("busy_timeout", ready_busy_n, 16'h0001);
         stop_test();
      end else begin
         check("busy_len", 16'(n + 30 > cyc), 16'h0001);
      end
   endtask
   // ==========================================================
   // main sequence
   initial begin
      seed = 32'h0044;
      error_cnt = 0;
      check_count = 0;
      rstn = 1'b0;
      // link side needs its own edges during reset
      fork
         repeat (5) @(posedge clk_sys);
         u_pnpp_prog.pulses(4);
      join
      @(posedge clk_sys);
      rstn <= 1'b1;
      u_pnpp_prog.pulses(4);
      check("reset_pins", {data_oe, ready_busy_n, prog_mode}, 16'h0002);
      u_pnpp_prog.enter(1'b1);
      check("mode_glitch", prog_mode, 1'b0);
      u_pnpp_prog.leave();
      u_pnpp_prog.enter(1'b0);
      check("mode_entry", {prog_mode, ready_busy_n}, 16'h0003);
      u_pnpp_prog.load(ACT_CMD, 1'b0, CMD_RD_SIG);
      for (int a = 0; a < 4; a++) begin
         u_pnpp_prog.load(ACT_ADDR, 1'b0, a[7:0]);
         u_pnpp_prog.read(1'b0, 1'b0, q);
         check("ident", q, sig_exp(a[7:0], 1'b0));
      end
      u_pnpp_prog.load(ACT_ADDR, 1'b0, 8'h00);
      u_pnpp_prog.read(1'b0, 1'b1, q);
      check("trim", q, sig_exp(8'h00, 1'b1));
      check("oe_off", data_oe, 1'b0);
      // fuse and lock writes before erase, so erase has something to keep or clear
      fv = 8'($random(seed));
      lv = 8'($random(seed));
      u_pnpp_prog.load(ACT_CMD, 1'b0, CMD_WR_FUSE);
      u_pnpp_prog.load(ACT_DATA, 1'b0, fv);
      u_pnpp_prog.write_pulse(1'b0);
      wait_ready(WR_CYC);
      u_pnpp_prog.load(ACT_CMD, 1'b0, CMD_WR_LOCK);
      u_pnpp_prog.load(ACT_DATA, 1'b0, lv);
      u_pnpp_prog.write_pulse(1'b0);
      wait_ready(WR_CYC);
      u_pnpp_prog.load(ACT_CMD, 1'b0, CMD_RD_FUSE);
      u_pnpp_prog.read(1'b0, 1'b1, q);
      check("lock_wr", q, lv);
      u_pnpp_prog.load(ACT_CMD, 1'b0, CMD_ERASE);
      u_pnpp_prog.write_pulse(1'b0);
      check("busy_erase", ready_busy_n, 1'b0);
      wait_ready(ER_CYC);
      u_pnpp_prog.load(ACT_CMD, 1'b0, CMD_RD_FUSE);
      for (int k = 0; k < 3; k++) begin
         u_pnpp_prog.read(k[1], k[0] | k[1], q);
         check("fuse_lock", q, k == 1 ? LOCK_RST : k == 0 ? fv : FUSE_HI_RST);
      end
      pg = 8'($random(seed));
      u_pnpp_prog.load(ACT_CMD, 1'b0, CMD_WR_FLASH);
      for (int w = 0; w < 64; w++) begin
         img[w] = 16'($random(seed));
         u_pnpp_prog.load(ACT_ADDR, 1'b0, {pg[1:0], w[5:0]});
         u_pnpp_prog.load(ACT_DATA, 1'b0, img[w][7:0]);
         u_pnpp_prog.load(ACT_DATA, 1'b1, img[w][15:8]);
         u_pnpp_prog.latch();
      end
      u_pnpp_prog.load(ACT_ADDR, 1'b1, {2'h0, pg[7:2]});
      u_pnpp_prog.write_pulse(1'b0);
      check("busy_flash", ready_busy_n, 1'b0);
      wait_ready(FL_CYC);
      u_pnpp_prog.load(ACT_CMD, 1'b0, CMD_NOP);
      u_pnpp_prog.load(ACT_CMD, 1'b0, CMD_RD_FLASH);
      u_pnpp_prog.load(ACT_ADDR, 1'b1, {2'h0, pg[7:2]});
      for (int w = 0; w < 65; w++) begin
         // last pass looks at a sibling page that must stay erased
         u_pnpp_prog.load(ACT_ADDR, 1'b0, w < 64 ? {pg[1:0], w[5:0]} : {~pg[1:0], 6'h00});
         u_pnpp_prog.read(1'b0, 1'b0, q);
         u_pnpp_prog.read(1'b0, 1'b1, qh);
         check("flash", {qh, q}, w < 64 ? img[w] : WORD_ERASED);
      end
      ea = 10'($random(seed));
      u_pnpp_prog.load(ACT_CMD, 1'b0, CMD_WR_EE);
      u_pnpp_prog.load(ACT_ADDR, 1'b1, {6'h00, ea[9:8]});
      for (int k = 0; k < 2; k++) begin
         ed[k] = 8'($random(seed));
         u_pnpp_prog.load(ACT_ADDR, 1'b0, ea[7:0] ^ k[7:0]);
         u_pnpp_prog.load(ACT_DATA, 1'b0, ed[k]);
         u_pnpp_prog.write_pulse(1'b0);
         check("busy_ee", ready_busy_n, 1'b0);
         wait_ready(WR_CYC);
      end
      u_pnpp_prog.load(ACT_CMD, 1'b0, CMD_RD_EE);
      for (int k = 0; k < 2; k++) begin
         u_pnpp_prog.load(ACT_ADDR, 1'b0, ea[7:0] ^ k[7:0]);
         u_pnpp_prog.load(ACT_IDLE, 1'b0, ~ea[7:0]);
         u_pnpp_prog.read(1'b0, 1'b0, q);
         check("eeprom", q, ed[k]);
      end
      stop_test();
   end
endmodule
